// *** sadc_defines.svh ***
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// register byte offsets on the avalon slave
`define SADC_OFS_RES_LOW 5'h00
`define SADC_OFS_RES_HIGH 5'h04
`define SADC_OFS_INPUT_SEL 5'h08
`define SADC_OFS_CTRL_A 5'h0c
`define SADC_OFS_CTRL_B 5'h10

// input_select_register fields
`define SADC_IS_REF_HI 7
`define SADC_IS_REF_LO 6
`define SADC_IS_LADJ 5
`define SADC_IS_MUX_HI 4
`define SADC_IS_MUX_LO 0

// converter_control_a fields
`define SADC_CA_EN 7
`define SADC_CA_START 6
`define SADC_CA_ATE 5
`define SADC_CA_DONE 4
`define SADC_CA_IE 3
`define SADC_CA_PS_HI 2
`define SADC_CA_PS_LO 0

// converter_control_b fields
`define SADC_CB_HSM 7
`define SADC_CB_TS_HI 2
`define SADC_CB_TS_LO 0

// reset values
`define SADC_RST_BYTE 8'h00
`define SADC_RST_TS 3'h0

// conversion timing, counted in half converter clock cycles
`define SADC_HALF_NORMAL 6'h1a
`define SADC_HALF_FIRST 6'h32
`define SADC_HALF_DIFF_HI 6'h1c
`define SADC_HALF_AUTO 6'h1b
`define SADC_SH_NORMAL 6'h03
`define SADC_SH_FIRST 6'h1b
`define SADC_SH_DIFF_HI 6'h05
`define SADC_SH_AUTO 6'h04

// trigger source code that selects the converter's own completion flag
`define SADC_TS_SELF 3'h0

`endif

// *** sadc_pkg.sv ***
package sadc_pkg;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } sadc_avs_req_type;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [4:0] chan_sel;
        logic analog_on;
        logic sample_hold;
        logic converting;
    } sadc_analog_type;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01
    } sadc_phase_type;

    typedef struct packed {
        logic [6:0] presc;
        logic half_clk;
        logic ack;
        logic [7:0] rdata;
        logic en;
        logic start;
        logic pend;
        logic ate;
        logic done;
        logic ie;
        logic [2:0] ps;
        logic [2:0] ts;
        logic hsm;
        logic [4:0] mux_reg;
        logic [1:0] ref_reg;
        logic ladj;
        logic [4:0] mux_act;
        logic [1:0] ref_act;
        logic [9:0] result;
        logic blocked;
        sadc_phase_type st;
        logic first;
        logic [5:0] halves;
        logic [5:0] total;
        logic [5:0] sh_at;
        logic samp;
        logic [7:0] trig_s1;
        logic [7:0] trig_s2;
        logic [7:0] trig_s3;
        logic [7:0] trig_lvl;
    } sadc_state_type;

endpackage

// *** sadc_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defines.svh"
// How it works
// - ten-bit result over two bytes, adjustable justification
// - low-byte read blocks updates until high read
// - blocked completion discards result, still flags done
// - start bit begins conversion, hardware clears it
// - channel change waits for current conversion end
// - auto trigger edge resets prescaler, starts conversion
// - edges during conversion ignored, no level restart
// - trigger flags set unmasked; software clears them
// - own done flag as trigger free-runs
// - start reads one while busy; manual start allowed
// - prescaler runs only while converter enabled
// - manual start waits for next converter clock rise
// - thirteen cycles normal, twenty-five for first
// - sample-hold at 1.5 cycles normal, 13.5 for first
// - completion writes result, sets done, clears start unless free running
// - auto trigger samples two cycles after edge
// - free running restarts at once, start stays high
// - differential start takes 14 when phase high
// - selections applied only while converter enabled
// - channel and gain field drives analog mux
// - reference field drives reference selector
// - selections track, lock during conversion, resume late
// - trigger select is bits 2..0, reset zero
module sadc_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire sadc_pkg::sadc_avs_req_type avs_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] trig_src_i,
    input wire logic [9:0] sar_result_i,
    output sadc_pkg::sadc_analog_type analog_o,
    output logic irq_o
);
    import sadc_pkg::*;

    sadc_state_type q;
    sadc_state_type d;

    // last prescaler count of one converter clock period for a divider code
    function automatic logic [6:0] presc_last(input logic [2:0] ps);
        logic [7:0] ratio;
        ratio = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
        return 7'(ratio - 8'h01);
    endfunction

    // count at which the converter clock falls, half way through the period
    function automatic logic [6:0] presc_mid(input logic [2:0] ps);
        logic [7:0] ratio;
        ratio = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
        return 7'((ratio >> 1) - 8'h01);
    endfunction

    logic req;
    logic acc;
    logic rise_tick;
    logic half_tick;
    logic trig_rise;
    logic diff_sel;
    logic finish;
    logic [5:0] halves_nx;
    logic [7:0] low_byte;
    logic [7:0] high_byte;
    logic [7:0] wbyte;

    // avalon handshake: one wait cycle, then the access takes effect
    assign req = avs_i.read | avs_i.write;
    assign acc = req & q.ack;
    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o = {24'h000000, q.rdata};
    assign wbyte = avs_i.writedata[7:0];

    // justification applies at read time so a change shows at once
    assign low_byte = q.ladj ? {q.result[1:0], 6'h00} : q.result[7:0];
    assign high_byte = q.ladj ? q.result[9:2] : {6'h00, q.result[9:8]};

    // codes with the upper mux bits set select a differential pair
    assign diff_sel = q.mux_reg[4:3] != 2'h0;

    assign analog_o.ref_sel = q.ref_act;
    assign analog_o.chan_sel = q.mux_act;
    assign analog_o.analog_on = q.en;
    assign analog_o.sample_hold = q.samp;
    assign analog_o.converting = q.st == SADC_CONV;
    assign irq_o = q.done & q.ie;

    // next-state logic for the whole block
    always_comb begin
        d = q;
        d.samp = 1'b0;
        finish = 1'b0;
        halves_nx = q.halves + 6'h01;

        // trigger inputs cross in from other logic: three flops, agree on two
        d.trig_s1 = trig_src_i;
        d.trig_s2 = q.trig_s1;
        d.trig_s3 = q.trig_s2;
        d.trig_lvl = (q.trig_s2 & q.trig_s3) | (q.trig_lvl & (q.trig_s2 | q.trig_s3));
        // a level that stays high gives no new edge until it has dropped again
        trig_rise = d.trig_lvl[q.ts] & ~q.trig_lvl[q.ts];

        // prescaler held at zero while disabled
        rise_tick = q.en && (q.presc == presc_last(q.ps));
        half_tick = q.en && (rise_tick || q.presc == presc_mid(q.ps));
        if (!q.en) begin
            d.presc = 7'h00;
            d.half_clk = 1'b0;
        end else if (rise_tick) begin
            d.presc = 7'h00;
            d.half_clk = ~q.half_clk;
        end else begin
            d.presc = q.presc + 7'h01;
        end

        // register access answer, latched for the cycle waitrequest drops
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            unique case (avs_i.address)
                `SADC_OFS_RES_LOW: d.rdata = low_byte;
                `SADC_OFS_RES_HIGH: d.rdata = high_byte;
                `SADC_OFS_INPUT_SEL: d.rdata = {q.ref_reg, q.ladj, q.mux_reg};
                `SADC_OFS_CTRL_A: d.rdata = {q.en, q.start | (q.st == SADC_CONV), q.ate,
                    q.done, q.ie, q.ps};
                `SADC_OFS_CTRL_B: d.rdata = {q.hsm, 4'h0, q.ts};
                default: d.rdata = `SADC_RST_BYTE;
            endcase
        end

        // read side effects on the result bytes
        if (acc && avs_i.read) begin
            if (avs_i.address == `SADC_OFS_RES_LOW) begin
                d.blocked = 1'b1;
            end
            if (avs_i.address == `SADC_OFS_RES_HIGH) begin
                d.blocked = 1'b0;
            end
        end

        // register writes; only the low byte lane carries data
        if (acc && avs_i.write && avs_i.byteenable[0]) begin
            unique case (avs_i.address)
                `SADC_OFS_INPUT_SEL: begin
                    d.ref_reg = wbyte[`SADC_IS_REF_HI:`SADC_IS_REF_LO];
                    d.ladj = wbyte[`SADC_IS_LADJ];
                    d.mux_reg = wbyte[`SADC_IS_MUX_HI:`SADC_IS_MUX_LO];
                end
                `SADC_OFS_CTRL_A: begin
                    d.en = wbyte[`SADC_CA_EN];
                    if (wbyte[`SADC_CA_EN] && !q.en) begin
                        d.first = 1'b1;
                    end
                    d.ate = wbyte[`SADC_CA_ATE];
                    d.ie = wbyte[`SADC_CA_IE];
                    d.ps = wbyte[`SADC_CA_PS_HI:`SADC_CA_PS_LO];
                    if (wbyte[`SADC_CA_DONE]) begin
                        d.done = 1'b0; // write one clears; a same-cycle set wins below
                    end
                    // a start is honoured with or without auto triggering
                    if (wbyte[`SADC_CA_START] && wbyte[`SADC_CA_EN] && q.st == SADC_IDLE) begin
                        d.start = 1'b1;
                        d.pend = 1'b1;
                    end
                end
                `SADC_OFS_CTRL_B: begin
                    d.hsm = wbyte[`SADC_CB_HSM];
                    d.ts = wbyte[`SADC_CB_TS_HI:`SADC_CB_TS_LO];
                end
                default: begin
                end
            endcase
        end

        // conversion sequencer
        unique case (q.st)
            SADC_IDLE: begin
                if (q.en && q.ate && q.ts != `SADC_TS_SELF && trig_rise) begin
                    // the sync flops supply the cpu-cycle delay before the start
                    d.presc = 7'h00;
                    d.half_clk = 1'b0;
                    d.st = SADC_CONV;
                    d.start = 1'b1;
                    d.pend = 1'b0;
                    d.halves = 6'h00;
                    d.total = `SADC_HALF_AUTO;
                    d.sh_at = `SADC_SH_AUTO;
                    d.first = 1'b0;
                end else if (q.pend && rise_tick) begin
                    d.st = SADC_CONV;
                    d.pend = 1'b0;
                    d.halves = 6'h00;
                    d.first = 1'b0;
                    if (q.first) begin
                        d.total = `SADC_HALF_FIRST;
                        d.sh_at = `SADC_SH_FIRST;
                    end else if (diff_sel && q.half_clk) begin
                        d.total = `SADC_HALF_DIFF_HI;
                        d.sh_at = `SADC_SH_DIFF_HI;
                    end else begin
                        d.total = `SADC_HALF_NORMAL;
                        d.sh_at = `SADC_SH_NORMAL;
                    end
                end
            end
            SADC_CONV: begin
                // trigger edges here are simply not looked at
                if (half_tick) begin
                    d.halves = halves_nx;
                    d.samp = halves_nx == q.sh_at;
                    finish = halves_nx == q.total;
                end
                if (finish) begin
                    d.done = 1'b1;
                    if (!q.blocked) begin
                        d.result = sar_result_i;
                    end
                    if (q.ate && q.ts == `SADC_TS_SELF) begin
                        // free running: restart now, start bit stays high
                        d.halves = 6'h00;
                        d.total = (diff_sel && q.half_clk) ? `SADC_HALF_DIFF_HI
                                                           : `SADC_HALF_NORMAL;
                        d.sh_at = (diff_sel && q.half_clk) ? `SADC_SH_DIFF_HI
                                                           : `SADC_SH_NORMAL;
                    end else begin
                        // a trigger still high here starts nothing new
                        d.st = SADC_IDLE;
                        d.start = 1'b0;
                    end
                end
            end
            default: d.st = SADC_IDLE;
        endcase

        // switching off abandons any conversion in flight
        if (!d.en) begin
            d.st = SADC_IDLE;
            d.start = 1'b0;
            d.pend = 1'b0;
        end

        // selections track while enabled and idle or in the last cycle, frozen otherwise
        if (q.en && (q.st == SADC_IDLE || q.halves + 6'h02 >= q.total)) begin
            d.mux_act = q.mux_reg;
            d.ref_act = q.ref_reg;
        end
    end

    // single state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.ts <= `SADC_RST_TS;
            q.st <= SADC_IDLE;
        end else begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

// *** sadc_ctrl_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire sadc_pkg::sadc_avs_req_type avs_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [7:0] trig_src_i,
    input wire logic [9:0] sar_result_i,
    input wire sadc_pkg::sadc_analog_type analog_o,
    input wire logic irq_o
);
    import sadc_pkg::*;
    logic [7:0] len_q;
    logic [7:0] len_d;
    // cycles of the running conversion; saturates so slow dividers cannot wrap it
    always_comb begin
        len_d = 8'h00;
        if (analog_o.converting) begin
            len_d = (len_q == 8'hff) ? len_q : len_q + 8'h01;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_q <= 8'h00;
        end else begin
            len_q <= len_d;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req_rise;
        $rose(avs_i.read || avs_i.write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    property p_bus_wait;
        s_req_rise |-> s_one_wait;
    endproperty
    property p_rd_upper;
        avs_readdata_o[31:8] == 24'h000000;
    endproperty
    property p_sh_in_conv;
        analog_o.sample_hold |-> analog_o.converting ##1 !analog_o.sample_hold;
    endproperty
    property p_off_idle;
        !analog_o.analog_on ##1 !analog_o.analog_on |-> !analog_o.converting;
    endproperty
    property p_sel_lock;
        $rose(analog_o.converting) |=> ($stable(analog_o.chan_sel) && $stable(analog_o.ref_sel))[*8];
    endproperty
    property p_off_hold;
        !analog_o.analog_on |=> analog_o.analog_on || $stable(analog_o.chan_sel);
    endproperty
    property p_min_len;
        $fell(analog_o.converting) && analog_o.analog_on |-> len_q >= 8'h18;
    endproperty
    property p_irq_cause;
        $rose(irq_o) |-> $past(analog_o.converting) || $past(avs_i.write);
    endproperty
    property p_irq_hold;
        $fell(irq_o) |-> $past(avs_i.write);
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("waitrequest timing wrong");
    a_rd_upper: assert property (p_rd_upper) else $error("readdata upper bits set");
    a_sh_in_conv: assert property (p_sh_in_conv) else $error("stray sample pulse");
    a_off_idle: assert property (p_off_idle) else $error("converting while off");
    a_sel_lock: assert property (p_sel_lock) else $error("selection moved");
    a_off_hold: assert property (p_off_hold) else $error("channel applied while off");
    a_min_len: assert property (p_min_len) else $error("conversion too short");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
endmodule
bind sadc_ctrl sadc_ctrl_chk i_sadc_ctrl_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_i(avs_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .trig_src_i(trig_src_i), .sar_result_i(sar_result_i), .analog_o(analog_o), .irq_o(irq_o));
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected at %0t got %h want %h", $time, (a), (e)); end end
module tb;
    import sadc_pkg::*;
    typedef struct {logic wr; logic [4:0] a; logic [7:0] d; logic [7:0] e;} sadc_row_type;
    localparam logic [4:0] o_lo = 5'h00;
    localparam logic [4:0] o_hi = 5'h04;
    localparam logic [4:0] o_is = 5'h08;
    localparam logic [4:0] o_ca = 5'h0c;
    localparam logic [4:0] o_cb = 5'h10;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    sadc_avs_req_type req = '0;
    logic [31:0] rdata;
    logic wreq;
    logic [7:0] trig = 8'h00;
    logic [9:0] sar = 10'h2a5;
    sadc_analog_type ana;
    logic irq;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    int sh;
    logic [7:0] q;
    sadc_row_type rows [14] = '{'{1'b0, o_lo, 8'h00, 8'h00}, '{1'b0, o_hi, 8'h00, 8'h00},
        '{1'b0, o_is, 8'h00, 8'h00}, '{1'b0, o_ca, 8'h00, 8'h00}, '{1'b0, o_cb, 8'h00, 8'h00},
        '{1'b1, o_cb, 8'hff, 8'h00}, '{1'b0, o_cb, 8'h00, 8'h87}, '{1'b1, o_cb, 8'h00, 8'h00},
        '{1'b1, o_is, 8'he5, 8'h00}, '{1'b0, o_is, 8'h00, 8'he5}, '{1'b1, 5'h14, 8'hff, 8'h00},
        '{1'b0, 5'h14, 8'h00, 8'h00}, '{1'b1, o_ca, 8'h0f, 8'h00}, '{1'b0, o_ca, 8'h00, 8'h0f}};
    sadc_ctrl i_sadc_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_i(req),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .trig_src_i(trig),
        .sar_result_i(sar), .analog_o(ana), .irq_o(irq));
    // 10 MHz clock and a hang guard well above the few hundred cycles needed
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one avalon access; waitrequest and read data are taken at the accepting rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        req <= '{a, !wr, wr, 4'h1, {24'h000000, d}};
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        if (k >= 20) err_total++;
        q = rdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    // measure one conversion in system cycles and where the sample pulse lands
    task automatic conv(input int len, input int shx);
        int k;
        k = 0;
        do begin
            @(negedge clk_sys_i);
            k++;
        end while (ana.converting !== 1'b1 && k < 200);
        n = 0;
        sh = -1;
        while (ana.converting === 1'b1 && n < 200) begin
            if (ana.sample_hold === 1'b1) sh = n;
            n++;
            @(negedge clk_sys_i);
        end
        `CHK(n, len)
        `CHK(sh, shx)
    endtask
    task automatic idle_wait();
        int k;
        k = 0;
        do begin
            bus(1'b0, o_ca, 8'h00);
            k++;
        end while (q[6] !== 1'b0 && k < 100);
    endtask
    // divider code 0 for every conversion: one converter cycle is two system cycles
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) `CHK(q, rows[i].e)
        end
        `CHK(ana.chan_sel, 5'h00)
        $display("register table finished");
        bus(1'b1, o_is, 8'h03);
        bus(1'b1, o_ca, 8'h88);
        repeat (2) @(negedge clk_sys_i);
        `CHK(ana.chan_sel, 5'h03)
        bus(1'b1, o_ca, 8'hc8);
        conv(50, 27);
        bus(1'b0, o_ca, 8'h00);
        `CHK(q, 8'h98)
        `CHK(irq, 1'b1)
        bus(1'b0, o_lo, 8'h00);
        `CHK(q, 8'ha5)
        bus(1'b0, o_hi, 8'h00);
        `CHK(q, 8'h02)
        bus(1'b1, o_ca, 8'h98);
        @(negedge clk_sys_i);
        `CHK(irq, 1'b0)
        $display("first conversion finished");
        bus(1'b1, o_is, 8'h23);
        bus(1'b1, o_ca, 8'hc8);
        conv(26, 3);
        bus(1'b0, o_lo, 8'h00);
        `CHK(q, 8'h40)
        bus(1'b0, o_hi, 8'h00);
        `CHK(q, 8'ha9)
        $display("left adjust finished");
        bus(1'b0, o_lo, 8'h00);
        sar <= 10'h3fe;
        bus(1'b1, o_ca, 8'hd8);
        bus(1'b0, o_ca, 8'h00);
        `CHK(q[6], 1'b1)
        bus(1'b1, o_is, 8'h25);
        @(negedge clk_sys_i);
        `CHK(ana.chan_sel, 5'h03)
        idle_wait();
        `CHK(q, 8'h98)
        `CHK(ana.chan_sel, 5'h05)
        bus(1'b0, o_hi, 8'h00);
        `CHK(q, 8'ha9)
        bus(1'b1, o_ca, 8'hd8);
        idle_wait();
        bus(1'b0, o_lo, 8'h00);
        `CHK(q, 8'h80)
        bus(1'b0, o_hi, 8'h00);
        `CHK(q, 8'hff)
        $display("read interlock finished");
        bus(1'b1, o_cb, 8'h01);
        bus(1'b1, o_ca, 8'hb8);
        trig <= 8'h02;
        fork
            conv(27, 4);
            begin
                repeat (15) @(posedge clk_sys_i);
                trig <= 8'h00;
                @(posedge clk_sys_i);
                trig <= 8'h02;
            end
        join
        repeat (60) @(negedge clk_sys_i);
        `CHK(ana.converting, 1'b0)
        bus(1'b1, o_ca, 8'he8);
        conv(26, 3);
        $display("auto trigger finished");
        bus(1'b1, o_cb, 8'h00);
        trig <= 8'h00;
        bus(1'b1, o_ca, 8'he8);
        sh = 0;
        repeat (200) begin
            @(negedge clk_sys_i);
            if (ana.sample_hold === 1'b1) sh++;
        end
        `CHK(sh >= 6, 1'b1)
        bus(1'b0, o_ca, 8'h00);
        `CHK(q[6], 1'b1)
        bus(1'b1, o_ca, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        `CHK(ana.analog_on, 1'b0)
        `CHK(ana.converting, 1'b0)
        $display("free running finished");
        report_and_stop();
    end
endmodule
`default_nettype wire
